// file: hdl/video_adjust_consts.svh
// Purpose: offsets, reset values and field positions of the video adjust block
// Assumes: register index times four is the AXI byte address
// Notes:   index values are kept as printed
`ifndef VIDEO_ADJUST_CONSTS_SVH
`define VIDEO_ADJUST_CONSTS_SVH
`define VA_IDX_SAT        6'h09
`define VA_IDX_BRI        6'h0A
`define VA_IDX_HUE        6'h0B
`define VA_IDX_DEFY       6'h0C
`define VA_IDX_DEFC       6'h0D
`define VA_IDX_DECIM      6'h0E
`define VA_IDX_STATUS     6'h10
`define VA_RST_SAT        8'h80
`define VA_RST_BRI        8'h00
`define VA_RST_HUE        8'h00
`define VA_RST_DEFY       8'h10
`define VA_RST_DEFC       8'h88
`define VA_RST_DECIM      7'h00
`define VA_BIT_FORCE      0
`define VA_BIT_AUTO       1
`define VA_BIT_DEC_EN     0
`define VA_CHROMA_MID     8'h80
`define VA_FIFO_DEPTH     8
`define VA_RESP_OKAY      2'b00
`define VA_RESP_SLVERR    2'b10
`endif

// file: hdl/video_adjust_pkg.sv
// Purpose: shared types of the video adjust block
// Assumes: nothing beyond the constants header
// Notes:   pixel word carries field markers alongside the samples
package video_adjust_pkg;
	typedef struct packed {
		logic [7:0] y;
		logic [7:0] cb;
		logic [7:0] cr;
		logic       fieldStart;
		logic       fieldOdd;
	} pix_t;
endpackage

// file: hdl/video_adjust_and_field_decimation.sv
// Purpose: colour adjust, default substitution and field decimation with AXI4-Lite registers
// Assumes: pixel stream and lock indication come from logic on clk
// Notes:   hue uses a linear sine/cosine approximation
// How it works
// - chroma gain set by saturation code
// - signed brightness offset added to luma
// - signed hue code rotates chroma phase
// - force bit substitutes default Y, Cr, Cb
// - auto bit substitutes defaults on lost lock
// - default luma from bits seven to two
// - default Cr/Cb nibbles, zero filled below
// - decimation only while enable bit set
// - codes 0/1 drop frames, chosen start parity
// - codes 2/3 drop even or odd fields
// - skip count fields/frames between outputs
`timescale 1ns/1ps
`include "video_adjust_consts.svh"

// ==========================================
// fifo
module pixel_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_q;
	logic [AW:0]      rdPtr_q;
	wire              full  = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
	wire              empty = (wrPtr_q == rdPtr_q);
	wire              push  = inValid && !full;
	wire              pop   = outReady && !empty;
	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = mem[rdPtr_q[AW-1:0]];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (push) wrPtr_q <= wrPtr_q + 1'b1;
			if (pop)  rdPtr_q <= rdPtr_q + 1'b1;
		end
	end
endmodule

// ==========================================
// top
module video_adjust_and_field_decimation (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  lockDetected,
	input  wire video_adjust_pkg::pix_t pixIn,
	input  wire logic                  pixInValid,
	output logic                       pixInReady,
	output video_adjust_pkg::pix_t     pixOut,
	output logic                       pixOutValid,
	input  wire logic                  pixOutReady
);
	// ==========================================
	// register bus
	logic [7:0] saturation_code_q, brightness_code_q, hue_q, defLumaCtl_q, default_chroma_q;
	logic [6:0] decim_q;
	logic [7:0] awAddr_q, rdIdxAddr;
	logic       awHeld_q, wHeld_q, restart_q, pass_q;
	logic [7:0] wData_q;
	logic       wLane_q;
	logic [3:0] skip_q;

	assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire       awTake  = s_axi_awvalid && s_axi_awready;
	wire       wTake   = s_axi_wvalid && s_axi_wready;
	wire       doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
	wire [5:0] wIdx    = awAddr_q[7:2];
	wire       wMapped = (awAddr_q[1:0] == 2'b00) && (wIdx >= `VA_IDX_SAT) && (wIdx <= `VA_IDX_DECIM);
	wire       wrEn    = doWrite && wMapped && wLane_q;
	// reserved bit seven is not stored, so it always reads zero
	wire       decimWr = wrEn && (wIdx == `VA_IDX_DECIM) && (wData_q[6:0] != decim_q);

	wire       arTake  = s_axi_arvalid && s_axi_arready;
	wire [5:0] rIdx    = s_axi_araddr[7:2];
	wire       rMapped = (s_axi_araddr[1:0] == 2'b00) &&
	                     (((rIdx >= `VA_IDX_SAT) && (rIdx <= `VA_IDX_DECIM)) || (rIdx == `VA_IDX_STATUS));
	wire       defActive;
	assign rdIdxAddr = (rIdx == `VA_IDX_SAT)    ? saturation_code_q :
	                   (rIdx == `VA_IDX_BRI)    ? brightness_code_q :
	                   (rIdx == `VA_IDX_HUE)    ? hue_q :
	                   (rIdx == `VA_IDX_DEFY)   ? defLumaCtl_q :
	                   (rIdx == `VA_IDX_DEFC)   ? default_chroma_q :
	                   (rIdx == `VA_IDX_DECIM)  ? {1'b0, decim_q} :
	                   (rIdx == `VA_IDX_STATUS) ? {3'h0, skip_q[0], restart_q, pass_q, defActive, lockDetected} :
	                   8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q  <= 8'h00;
			wLane_q  <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `VA_RESP_OKAY;
		end else begin
			if (awTake) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (wTake) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata[7:0];
				wLane_q <= s_axi_wstrb[0];
			end
			if (doWrite) begin
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wMapped ? `VA_RESP_OKAY : `VA_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `VA_RESP_OKAY;
		end else if (arTake) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rdIdxAddr};
			s_axi_rresp  <= rMapped ? `VA_RESP_OKAY : `VA_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			saturation_code_q <= `VA_RST_SAT;
			brightness_code_q <= `VA_RST_BRI;
			hue_q             <= `VA_RST_HUE;
			defLumaCtl_q      <= `VA_RST_DEFY;
			default_chroma_q  <= `VA_RST_DEFC;
			decim_q           <= `VA_RST_DECIM;
		end else if (wrEn) begin
			if (wIdx == `VA_IDX_SAT)   saturation_code_q <= wData_q;
			if (wIdx == `VA_IDX_BRI)   brightness_code_q <= wData_q;
			if (wIdx == `VA_IDX_HUE)   hue_q             <= wData_q;
			if (wIdx == `VA_IDX_DEFY)  defLumaCtl_q      <= wData_q;
			if (wIdx == `VA_IDX_DEFC)  default_chroma_q  <= wData_q;
			if (wIdx == `VA_IDX_DECIM) decim_q           <= wData_q[6:0];
		end
	end

	// ==========================================
	// colour adjust
	function automatic logic [7:0] clampOffset(input logic signed [15:0] v);
		if (v > 16'sd127)       clampOffset = 8'hFF;
		else if (v < -16'sd128) clampOffset = 8'h00;
		else                    clampOffset = v[7:0] + `VA_CHROMA_MID;
	endfunction

	wire signed [8:0]  cbS    = $signed({1'b0, pixIn.cb}) - 9'sd128;
	wire signed [8:0]  crS    = $signed({1'b0, pixIn.cr}) - 9'sd128;
	wire signed [8:0]  hueS   = {hue_q[7], hue_q};
	wire        [7:0]  hueMag = hue_q[7] ? 8'(-hue_q) : hue_q;
	// cosine falls linearly to zero at a quarter turn; cheaper than a table
	// full scale of 128 at zero hue keeps neutral settings bit exact
	wire signed [8:0]  cosS   = 9'sd128 - $signed({1'b0, hueMag});
	wire signed [18:0] cbRot  = 19'(cbS * cosS) - 19'(crS * hueS);
	wire signed [18:0] crRot  = 19'(crS * cosS) + 19'(cbS * hueS);
	wire signed [9:0]  satS   = {2'b00, saturation_code_q};
	wire signed [23:0] cbSat  = 24'(cbRot >>> 7) * satS;
	wire signed [23:0] crSat  = 24'(crRot >>> 7) * satS;
	wire signed [9:0]  yAdj   = $signed({2'b00, pixIn.y}) + {{2{brightness_code_q[7]}}, brightness_code_q};
	wire        [7:0]  yClamp = yAdj[9] ? 8'h00 : (yAdj[8] ? 8'hFF : yAdj[7:0]);

	assign defActive = defLumaCtl_q[`VA_BIT_FORCE] ||
	                   (defLumaCtl_q[`VA_BIT_AUTO] && !lockDetected);
	wire [7:0] defY  = {defLumaCtl_q[7:2], 2'b00};
	wire [7:0] defCr = {default_chroma_q[7:4], 4'h0};
	wire [7:0] defCb = {default_chroma_q[3:0], 4'h0};

	video_adjust_pkg::pix_t adjPix;
	assign adjPix.y          = defActive ? defY  : yClamp;
	assign adjPix.cb         = defActive ? defCb : clampOffset(16'(cbSat >>> 7));
	assign adjPix.cr         = defActive ? defCr : clampOffset(16'(crSat >>> 7));
	assign adjPix.fieldStart = pixIn.fieldStart;
	assign adjPix.fieldOdd   = pixIn.fieldOdd;

	// ==========================================
	// field decimation
	wire       decEn     = decim_q[`VA_BIT_DEC_EN];
	wire [1:0] pattern   = decim_q[2:1];
	wire [3:0] skipCount = decim_q[6:3];
	wire       frameMode = !pattern[1];
	// key parity opens a frame, or is the parity that survives field dropping
	wire       keyParity = frameMode ? pattern[0] : !pattern[0];
	wire       accept    = pixInValid && pixInReady;
	wire       boundary  = accept && pixIn.fieldStart;
	wire       isKey     = (pixIn.fieldOdd == keyParity);
	wire       keyPass   = restart_q || (skip_q == 4'h0);
	wire       fieldPass = !decEn ? 1'b1 :
	                       isKey ? keyPass :
	                       (frameMode && !restart_q && pass_q);
	// disabling mid-field must not keep dropping the rest of that field
	wire       passNow   = !decEn || (pixIn.fieldStart ? fieldPass : pass_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pass_q    <= 1'b1;
			skip_q    <= 4'h0;
			restart_q <= 1'b1;
		end else begin
			if (boundary) pass_q <= fieldPass;
			if (boundary && decEn && isKey) skip_q <= keyPass ? skipCount : skip_q - 4'h1;
			// a settings change in the boundary cycle wins over the clear
			if (decimWr || !decEn)              restart_q <= 1'b1;
			else if (boundary && isKey) restart_q <= 1'b0;
		end
	end

	pixel_fifo #(
		.WIDTH ($bits(video_adjust_pkg::pix_t)),
		.DEPTH (`VA_FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.inValid  (pixInValid && passNow),
		.inReady  (pixInReady),
		.inData   (adjPix),
		.outValid (pixOutValid),
		.outReady (pixOutReady),
		.outData  (pixOut)
	);

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire fifoPush = pixInValid && passNow && pixInReady;

	a_force_default: assert property (defLumaCtl_q[0] && fifoPush |-> adjPix.y == {defLumaCtl_q[7:2], 2'b00})
		else $error("forced default luma wrong");
	a_auto_default: assert property (defLumaCtl_q[1] && !lockDetected && fifoPush |->
		adjPix.cr == {default_chroma_q[7:4], 4'h0} && adjPix.cb == {default_chroma_q[3:0], 4'h0})
		else $error("auto default chroma wrong");
	a_neutral_pass: assert property (saturation_code_q == 8'h80 && hue_q == 8'h00 && brightness_code_q == 8'h00
		&& !defActive && fifoPush |-> adjPix.y == pixIn.y && adjPix.cr == pixIn.cr)
		else $error("neutral settings altered video");
	a_sat_zero: assert property (saturation_code_q == 8'h00 && !defActive && fifoPush |-> adjPix.cb == 8'h80)
		else $error("zero saturation kept chroma");
	a_bright_up: assert property (brightness_code_q == 8'h7F && !defActive && fifoPush && pixIn.y < 8'h80
		|-> adjPix.y == pixIn.y + 8'h7F)
		else $error("brightness offset wrong");
	a_decim_off: assert property (!decEn && accept |-> fifoPush)
		else $error("field dropped while decimation off");
	a_even_drop: assert property (decEn && pattern == 2'b10 && boundary && !pixIn.fieldOdd |-> !fifoPush)
		else $error("even field not suppressed");
	sequence keyPassed;
		boundary && decEn && isKey && keyPass;
	endsequence
	a_skip_load: assert property (keyPassed ##1 !decimWr[*1] |-> skip_q == $past(skipCount))
		else $error("skip counter not reloaded");
	a_frame_pair: assert property (boundary && decEn && frameMode && !isKey && !restart_q |-> fieldPass == pass_q)
		else $error("frame halves disagree");
	a_restart_set: assert property (decimWr |=> restart_q)
		else $error("restart not armed on change");
	sequence wrIssued;
		awTake ##0 wTake;
	endsequence
	a_axi_bresp: assert property (wrIssued |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
endmodule

// file: sim/video_sink.sv
// Purpose: downstream pixel sink model
// Assumes: one pixel word per handshake
// Notes:   slow mode takes every other cycle
`timescale 1ns/1ps
module video_sink (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire video_adjust_pkg::pix_t pixOut,
	input  wire logic                   pixOutValid,
	output logic                        pixOutReady,
	input  wire logic                   stall,
	input  wire logic                   slow
);
	// ====
	// acceptance
	video_adjust_pkg::pix_t got[$];
	logic                   toggle_q;
	assign pixOutReady = !stall && !(slow && toggle_q);
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			toggle_q <= 1'b0;
		else begin
			toggle_q <= !toggle_q;
			if (pixOutValid && pixOutReady)
				got.push_back(pixOut);
		end
	end
endmodule

// file: sim/video_adjust_and_field_decimation_tb.sv
// Purpose: self-checking bench of the video adjust block
// Assumes: bus answers per the hand-over timing
// Notes:   field index rides in luma during decimation runs
`timescale 1ns/1ps
`include "video_adjust_consts.svh"
module video_adjust_and_field_decimation_tb;
	logic                   clk, rst, awvalid, wvalid, bready, arvalid, rready, lockDetected, pixInValid, stall, slow;
	logic                   awready, wready, bvalid, arready, rvalid, pixInReady, pixOutReady, pixOutValid;
	logic [7:0]             awaddr, araddr;
	logic [3:0]             wstrb;
	logic [31:0]            wdata, rdata;
	logic [1:0]             bresp, rresp;
	video_adjust_pkg::pix_t pixIn, pixOut;
	int                     fails = 0;
	int                     n_checks = 0;
	video_adjust_and_field_decimation dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lockDetected(lockDetected),
		.pixIn(pixIn), .pixInValid(pixInValid), .pixInReady(pixInReady), .pixOut(pixOut),
		.pixOutValid(pixOutValid), .pixOutReady(pixOutReady));
	video_sink sink (.clk(clk), .rst(rst), .pixOut(pixOut), .pixOutValid(pixOutValid),
		.pixOutReady(pixOutReady), .stall(stall), .slow(slow));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ====
	// helpers
	task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic axiWrite(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic sendPix(input logic [7:0] y, cb, cr, input logic fs, odd);
		@(posedge clk);
		pixIn <= '{y, cb, cr, fs, odd};
		pixInValid <= 1'b1;
		forever begin
			@(posedge clk);
			if (pixInReady === 1'b1) break;
		end
		pixInValid <= 1'b0;
	endtask
	task automatic pixTest(input logic [23:0] inPix, input logic [23:0] exp, input string what);
		video_adjust_pkg::pix_t p;
		sink.got.delete();
		sendPix(inPix[23:16], inPix[15:8], inPix[7:0], 1'b0, 1'b0);
		repeat (6) @(posedge clk);
		cmpVal(sink.got.size(), 1, what);
		p = sink.got.pop_front();
		cmpVal({p.y, p.cb, p.cr}, exp, what);
	endtask
	// ====
	// scenarios
	task automatic regTest();
		logic [7:0]  addrs[6] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38};
		logic [7:0]  rsts[6] = '{8'h80, 8'h00, 8'h00, 8'h10, 8'h88, 8'h00};
		logic [31:0] d;
		logic [1:0]  r;
		foreach (addrs[i]) begin
			axiRead(addrs[i], d, r);
			cmpVal(d, rsts[i], "reset value");
			axiWrite(addrs[i], 8'h5A, r);
			axiRead(addrs[i], d, r);
			cmpVal(d, 32'h5A, "readback");
			axiWrite(addrs[i], rsts[i], r);
		end
		wstrb <= 4'h0;
		axiWrite(8'h24, 8'h11, r);
		wstrb <= 4'hF;
		axiRead(8'h24, d, r);
		cmpVal(d, 32'h80, "strobe off");
		axiWrite(8'h3C, 8'h11, r);
		cmpVal(r, `VA_RESP_SLVERR, "unmapped write");
		axiRead(8'h3C, d, r);
		cmpVal(r, `VA_RESP_SLVERR, "unmapped read");
		cmpVal(d, 32'h0, "unmapped data");
		axiRead(8'h40, d, r);
		cmpVal(d & 32'h1, 32'h1, "lock status");
		$display("test registers done");
	endtask
	task automatic adjustTest();
		logic [1:0] r;
		pixTest(24'h5030C0, 24'h5030C0, "identity");
		axiWrite(8'h28, 8'h7F, r);
		pixTest(24'h5030C0, 24'hCF30C0, "brighter");
		axiWrite(8'h28, 8'h80, r);
		pixTest(24'h5030C0, 24'h0030C0, "darker");
		axiWrite(8'h28, 8'h00, r);
		axiWrite(8'h2C, 8'h7F, r);
		pixTest(24'h5080C0, 24'h504080, "hue turn");
		axiWrite(8'h2C, 8'h80, r);
		pixTest(24'h5080C0, 24'h50C080, "hue back");
		axiWrite(8'h2C, 8'h00, r);
		axiWrite(8'h24, 8'h00, r);
		pixTest(24'h5030C0, 24'h508080, "sat min");
		axiWrite(8'h24, 8'hFF, r);
		pixTest(24'h50C080, 24'h50FF80, "sat max");
		axiWrite(8'h24, 8'h80, r);
		$display("test adjust done");
	endtask
	task automatic defaultTest();
		logic [1:0] r;
		axiWrite(8'h34, 8'h3C, r);
		axiWrite(8'h30, 8'hA5, r);
		pixTest(24'h5030C0, 24'hA4C030, "forced");
		axiWrite(8'h30, 8'hA6, r);
		lockDetected <= 1'b0;
		pixTest(24'h5030C0, 24'hA4C030, "unlocked");
		lockDetected <= 1'b1;
		pixTest(24'h5030C0, 24'h5030C0, "locked");
		axiWrite(8'h30, 8'hA4, r);
		lockDetected <= 1'b0;
		pixTest(24'h5030C0, 24'h5030C0, "no auto");
		lockDetected <= 1'b1;
		$display("test defaults done");
	endtask
	task automatic fifoTest();
		sink.got.delete();
		stall <= 1'b1;
		for (int i = 0; i < 8; i++) sendPix(8'(i), 8'h80, 8'h80, 1'b0, 1'b0);
		@(posedge clk);
		cmpVal(pixInReady, 1'b0, "full");
		cmpVal(pixOutValid, 1'b1, "held");
		stall <= 1'b0;
		repeat (12) @(posedge clk);
		cmpVal(sink.got.size(), 8, "drained");
		cmpVal(pixOutValid, 1'b0, "empty");
		$display("test buffer done");
	endtask
	// one pixel per field, even parity first
	task automatic decimTest(input logic [7:0] cfg, input logic [7:0] mask);
		logic [1:0] r;
		logic [7:0] gotMask;
		gotMask = 8'h00;
		sink.got.delete();
		axiWrite(8'h38, cfg, r);
		for (int i = 0; i < 8; i++) sendPix(8'(i), 8'h80, 8'h80, 1'b1, i[0]);
		repeat (12) @(posedge clk);
		foreach (sink.got[k]) gotMask[sink.got[k].y[2:0]] = 1'b1;
		cmpVal(sink.got.size(), $countones(mask), "field count");
		cmpVal(gotMask, mask, "fields kept");
		$display("test decimation %h done", cfg);
	endtask
	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready, pixInValid, stall, slow} = 9'h100;
		{awaddr, araddr, wdata} = '0;
		pixIn = '0;
		wstrb = 4'hF;
		lockDetected = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		regTest();
		adjustTest();
		defaultTest();
		fifoTest();
		slow <= 1'b1;
		decimTest(8'h00, 8'hFF);
		decimTest(8'h05, 8'hAA);
		decimTest(8'h0F, 8'h11);
		decimTest(8'h09, 8'h33);
		decimTest(8'h03, 8'hFE);
		decimTest(8'h7F, 8'h01);
		stop_test();
	end
	// whole run is a few hundred cycles
	initial begin
		#400000;
		fails++;
		stop_test();
	end
endmodule
